// ==== rtl/pm_msi_pkg.sv ====
// Package: offsets, field layouts and defaults of the PM and MSI registers
package pm_msi_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses in configuration space)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_PM_CSR   = 8'h44;
  localparam logic [7:0] OFF_MSI_CTRL = 8'h4C;
  localparam logic [7:0] OFF_MSI_ADDR = 8'h50;

  // ---------------------------------------------------------------------
  // Power management dword fields
  // ---------------------------------------------------------------------
  localparam int PM_STATE_LO    = 0;
  localparam int PM_NO_RST_BIT  = 3;
  localparam int PME_EN_BIT     = 8;
  localparam int DATA_SEL_LO    = 9;
  localparam int DATA_SCALE_LO  = 13;
  localparam int PME_STAT_BIT   = 15;
  localparam int BRIDGE_EXT_LO  = 16;
  localparam int PWR_DATA_LO    = 24;

  localparam logic       NO_RST_DEFAULT   = 1'b1;
  localparam logic [7:0] PWR_DATA_DEFAULT = 8'h00;
  localparam logic [1:0] DATA_SCALE_VAL   = 2'h0;
  localparam logic [7:0] BRIDGE_EXT_VAL   = 8'h00;
  localparam logic       PME_STAT_VAL     = 1'b0;

  // ---------------------------------------------------------------------
  // MSI capability fields
  // ---------------------------------------------------------------------
  localparam logic [7:0] MSI_CAP_ID      = 8'h05;
  localparam logic [7:0] MSI_NEXT_PTR    = 8'h64;
  localparam int         MSI_EN_BIT      = 16;
  localparam int         MM_CAP_LO       = 17;
  localparam int         MM_EN_LO        = 20;
  localparam int         ADDR64_BIT      = 23;
  localparam logic [2:0] MM_CAP_VAL      = 3'h0;
  localparam logic       ADDR64_VAL      = 1'b1;
  localparam int         MSG_ADDR_LO     = 2;

  // ---------------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_D0     = 2'b00,
    PS_D1     = 2'b01,
    PS_D2     = 2'b10,
    PS_D3_HOT = 2'b11
  } power_state_t;

  // Configuration request from the host side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Sideband default override (SMBus, I2C or EEPROM loader)
  typedef struct packed {
    logic       load;
    logic       no_rst;
    logic [7:0] pwr_data;
  } dflt_load_t;

endpackage

// ==== rtl/msi_addr_store.sv ====
// Storage word for the MSI message address with registered read data
`timescale 1ns/1ps
module msi_addr_store
  import pm_msi_pkg::*;
#(
  parameter int WIDTH = 30
)
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic [3:0]       be_in,
  input  wire logic             wr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] rdata_out
);

  logic [WIDTH+1:0] word;
  logic [WIDTH+1:0] wfull;
  logic [WIDTH+1:0] next_word;

  assign wfull = {wdata_in, 2'h0};

  // ---------------------------------------------------------------------
  // Byte-lane merge
  // ---------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign next_word[g*8 +: 8] = (wr_in && be_in[g]) ? wfull[g*8 +: 8]
                                                       : word[g*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      word      <= '0;
      rdata_out <= '0;
    end
    else
    begin
      word      <= {next_word[WIDTH+1:MSG_ADDR_LO], 2'h0};
      rdata_out <= next_word[WIDTH+1:MSG_ADDR_LO];
    end
  end

endmodule

// ==== rtl/pm_msi_cap_regs.sv ====
// Power management and MSI capability registers of one switch port
`timescale 1ns/1ps

// Contract
// - Power state field holds D0..D3hot as 00..11 and resets to D0.
// - Writing D0 while in D3hot fires a hot reset, downstream reset idle.
// - Read-only skip-reset flag, reset high, suppresses internal reset.
// - PME enable is writable, resets low, and enables the PME message.
// - PME status always reads zero.
// - Bridge support extension bits are hardwired zero, read-only.
// - Read-only power data byte resets to zero unless reloaded.
// - Skip-reset flag and power data byte are loadable from the sideband.
// - MSI capability identifier reads 05h.
// - MSI next pointer reads 64h, read-only.
// - With MSI enabled, interrupts go as MSI writes, never INTx.
// - With MSI disabled, which is the reset value, no MSI is issued.
// - The 64-bit address capable bit reads one.
// - Message address holds bits 31:2, resets to zero, bits 1:0 zero.
// - Message address is the MSI target only while MSI is enabled.
module pm_msi_cap_regs
  import pm_msi_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire cfg_req_t    cfg_req_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_rvalid_out,
  input  wire dflt_load_t  dflt_load_in,
  input  wire logic        irq_event_in,
  output logic             msi_req_out,
  output logic [31:0]      msi_addr_out,
  output logic             intx_assert_out,
  output logic             pme_msg_out,
  output logic             hot_reset_out,
  output logic             internal_reset_out,
  output logic             downstream_reset_out_n,
  output logic [1:0]       power_state_out
);

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire logic wr_pm   = cfg_req_in.wr && hit(cfg_req_in.addr, OFF_PM_CSR);
  wire logic wr_msi  = cfg_req_in.wr && hit(cfg_req_in.addr, OFF_MSI_CTRL);
  wire logic wr_addr = cfg_req_in.wr && hit(cfg_req_in.addr, OFF_MSI_ADDR);
  wire logic wr_pm_b0  = wr_pm && cfg_req_in.be[0];
  wire logic wr_pm_b1  = wr_pm && cfg_req_in.be[1];
  wire logic wr_msi_b2 = wr_msi && cfg_req_in.be[2];

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  power_state_t pstate;
  logic         pme_en;
  logic [3:0]   data_sel;
  logic         no_rst;
  logic [7:0]   pwr_data;
  logic         msi_en;
  logic [2:0]   mm_en;
  logic [29:0]  addr_q;

  wire power_state_t wr_state =
    power_state_t'(cfg_req_in.wdata[PM_STATE_LO +: 2]);
  wire logic wake_d3 = wr_pm_b0 && (pstate == PS_D3_HOT)
                       && (wr_state == PS_D0);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      pstate   <= PS_D0;
      pme_en   <= 1'b0;
      data_sel <= 4'h0;
      msi_en   <= 1'b0;
      mm_en    <= 3'h0;
    end
    else
    begin
      if (wr_pm_b0)
        pstate <= wr_state;
      if (wr_pm_b1)
      begin
        pme_en   <= cfg_req_in.wdata[PME_EN_BIT];
        data_sel <= cfg_req_in.wdata[DATA_SEL_LO +: 4];
      end
      if (wr_msi_b2)
      begin
        msi_en <= cfg_req_in.wdata[MSI_EN_BIT];
        mm_en  <= cfg_req_in.wdata[MM_EN_LO +: 3];
      end
    end
  end

  // Read-only defaults; the sideband loader may overwrite them any time outside reset
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      no_rst   <= NO_RST_DEFAULT;
      pwr_data <= PWR_DATA_DEFAULT;
    end
    else if (dflt_load_in.load)
    begin
      no_rst   <= dflt_load_in.no_rst;
      pwr_data <= dflt_load_in.pwr_data;
    end
  end

  msi_addr_store #(
    .WIDTH (30)
  ) u_addr (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .be_in      (cfg_req_in.be),
    .wr_in      (wr_addr),
    .wdata_in   (cfg_req_in.wdata[31:MSG_ADDR_LO]),
    .rdata_out  (addr_q)
  );

  // ---------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------
  wire logic [31:0] pm_word = {pwr_data,
                               BRIDGE_EXT_VAL,
                               PME_STAT_VAL,
                               DATA_SCALE_VAL,
                               data_sel,
                               pme_en,
                               4'h0,
                               no_rst,
                               1'b0,
                               pstate};
  wire logic [31:0] msi_word = {8'h00,
                                ADDR64_VAL,
                                mm_en,
                                MM_CAP_VAL,
                                msi_en,
                                MSI_NEXT_PTR,
                                MSI_CAP_ID};
  wire logic [31:0] addr_word = {addr_q, 2'h0};

  wire logic [31:0] next_rdata =
    hit(cfg_req_in.addr, OFF_PM_CSR)   ? pm_word  :
    hit(cfg_req_in.addr, OFF_MSI_CTRL) ? msi_word :
    hit(cfg_req_in.addr, OFF_MSI_ADDR) ? addr_word : 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Events and outputs
  // ---------------------------------------------------------------------
  // Internal reset only when the skip flag is low
  wire logic next_int_rst = wake_d3 && !no_rst;
  wire logic next_msi     = irq_event_in && msi_en;
  wire logic next_intx    = irq_event_in && !msi_en;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cfg_rdata_out      <= 32'h0000_0000;
      cfg_rvalid_out     <= 1'b0;
      hot_reset_out      <= 1'b0;
      internal_reset_out <= 1'b0;
      msi_req_out        <= 1'b0;
      msi_addr_out       <= 32'h0000_0000;
      intx_assert_out    <= 1'b0;
      pme_msg_out        <= 1'b0;
    end
    else
    begin
      cfg_rdata_out      <= cfg_req_in.rd ? next_rdata : cfg_rdata_out;
      cfg_rvalid_out     <= cfg_req_in.rd;
      hot_reset_out      <= wake_d3;
      internal_reset_out <= next_int_rst;
      msi_req_out        <= next_msi;
      // Address only presented with MSI enabled
      msi_addr_out       <= msi_en ? addr_word : 32'h0000_0000;
      intx_assert_out    <= next_intx;
      pme_msg_out        <= pme_en;
    end
  end

  // Hot reset from D3hot wake never touches the downstream pin
  assign downstream_reset_out_n = 1'b1;
  assign power_state_out        = pstate;

endmodule

// ==== testbench/pm_msi_cap_regs_asserts.sv ====
// Port checker for the PM and MSI capability registers
`timescale 1ns/1ps
module pm_msi_cap_regs_asserts
  import pm_msi_pkg::*;
(
  input wire logic         clk_sys_in,
  input wire logic         rst_in,
  input wire cfg_req_t     cfg_req_in,
  input wire logic [31:0]  cfg_rdata_out,
  input wire logic         cfg_rvalid_out,
  input wire logic         irq_event_in,
  input wire logic         msi_req_out,
  input wire logic [31:0]  msi_addr_out,
  input wire logic         intx_assert_out,
  input wire logic         pme_msg_out,
  input wire logic         hot_reset_out,
  input wire logic         internal_reset_out,
  input wire logic         downstream_reset_out_n,
  input wire logic [1:0]   power_state_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire logic pm_wr = cfg_req_in.wr && cfg_req_in.addr == OFF_PM_CSR;
  wire logic d0_wr = pm_wr && cfg_req_in.be[0]
                     && cfg_req_in.wdata[1:0] == 2'h0;
  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  hot_wake_a: assert property
    (d0_wr && power_state_out == PS_D3_HOT |=> hot_reset_out)
    else $error("no hot reset on wake");
  hot_cause_a: assert property
    (hot_reset_out |-> $past(power_state_out) == PS_D3_HOT)
    else $error("hot reset without wake");
  dn_idle_a: assert property (downstream_reset_out_n)
    else $error("downstream reset driven");
  int_reset_a: assert property (internal_reset_out |-> hot_reset_out)
    else $error("internal reset alone");
  state_wr_a: assert property
    (pm_wr && cfg_req_in.be[0] |=>
       power_state_out == $past(cfg_req_in.wdata[1:0]))
    else $error("power state not written");
  pme_move_a: assert property
    ($changed(pme_msg_out) |-> $past(pm_wr) || $past(pm_wr, 2))
    else $error("pme moved without write");
  irq_route_a: assert property
    (irq_event_in |=> msi_req_out != intx_assert_out)
    else $error("interrupt route wrong");
  addr_gate_a: assert property
    (intx_assert_out |-> msi_addr_out == 32'h0)
    else $error("address shown while disabled");
  addr_low_a: assert property (msi_addr_out[1:0] == 2'h0)
    else $error("address low bits set");
  pm_read_a: assert property
    (cfg_rvalid_out && $past(cfg_req_in.addr) == OFF_PM_CSR
       |-> cfg_rdata_out[23:15] == 9'h0)
    else $error("pm fixed bits wrong");
  msi_read_a: assert property
    (cfg_rvalid_out && $past(cfg_req_in.addr) == OFF_MSI_CTRL
       |-> cfg_rdata_out[23]
           && cfg_rdata_out[15:0] == {MSI_NEXT_PTR, MSI_CAP_ID})
    else $error("msi header wrong");
  cover property (hot_reset_out && internal_reset_out);
  cover property (msi_req_out);
  cover property (intx_assert_out);
endmodule
bind pm_msi_cap_regs pm_msi_cap_regs_asserts u_asserts (.clk_sys_in, .rst_in,
  .cfg_req_in, .cfg_rdata_out, .cfg_rvalid_out, .irq_event_in, .msi_req_out,
  .msi_addr_out, .intx_assert_out, .pme_msg_out, .hot_reset_out,
  .internal_reset_out, .downstream_reset_out_n, .power_state_out);

// ==== testbench/cfg_host_model.sv ====
// Host model issuing configuration writes and reads
`timescale 1ns/1ps
module cfg_host_model
  import pm_msi_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic [31:0] cfg_rdata_in,
  input  wire logic        cfg_rvalid_in,
  output cfg_req_t         cfg_req_out,
  output logic             timeout_out
);
  initial cfg_req_out = '0;
  initial timeout_out = 1'b0;
  // Released lines flip so stale values never pass for live ones
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b,
                           input logic [31:0] d);
    @(negedge clk_sys_in);
    cfg_req_out = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
    @(negedge clk_sys_in);
    cfg_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~b, wdata: ~d};
  endtask
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    int i;
    @(negedge clk_sys_in);
    cfg_req_out = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
    @(negedge clk_sys_in);
    cfg_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: '1};
    for (i = 0; i < 4 && cfg_rvalid_in !== 1'b1; i++)
      @(negedge clk_sys_in);
    timeout_out = (cfg_rvalid_in !== 1'b1);
    d = cfg_rdata_in;
  endtask
endmodule

// ==== testbench/pm_msi_cap_regs_test.sv ====
// Self-checking bench for the PM and MSI capability registers
`timescale 1ns/1ps
module pm_msi_cap_regs_test;
  import pm_msi_pkg::*;
  typedef struct packed
  {
    logic [7:0] a; logic [3:0] b; logic [31:0] d; logic [31:0] e;
  } row_t;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic irq_event_in = 1'b0;
  dflt_load_t dflt_load_in = '0;
  cfg_req_t cfg_req;
  logic [31:0] rdata, got;
  logic rvalid, msi_req, intx, pme, hot, irst, dn_n;
  logic [31:0] msi_addr;
  logic [1:0] pstate;
  int bad_count = 0;
  int n_checks = 0;
  row_t rows [13] = '{
    {8'h44, 4'h0, 32'hFFFFFFFF, 32'h00000008},   // Reset values
    {8'h4C, 4'h0, 32'hFFFFFFFF, 32'h00806405},
    {8'h50, 4'h0, 32'hFFFFFFFF, 32'h00000000},
    {8'h44, 4'h1, 32'h00000001, 32'h00000009},
    {8'h44, 4'h1, 32'h00000002, 32'h0000000A},
    {8'h44, 4'hF, 32'hFFFFFFFF, 32'h00001F0B},
    {8'h4C, 4'hF, 32'hFFFFFFFF, 32'h00F16405},
    {8'h50, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFFC},
    {8'h60, 4'hF, 32'hFFFFFFFF, 32'h00000000},
    {8'h50, 4'h1, 32'h00000000, 32'hFFFFFF00},
    {8'h4C, 4'hB, 32'h00000000, 32'h00F16405},
    {8'h4C, 4'h4, 32'h00000000, 32'h00806405},
    {8'h44, 4'h2, 32'h00000000, 32'h0000000B}};
  always #4 clk_sys_in = ~clk_sys_in;
  cfg_host_model u_host (.clk_sys_in(clk_sys_in), .cfg_rdata_in(rdata),
    .cfg_rvalid_in(rvalid), .cfg_req_out(cfg_req), .timeout_out());
  pm_msi_cap_regs u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cfg_req_in(cfg_req), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
    .dflt_load_in(dflt_load_in), .irq_event_in(irq_event_in),
    .msi_req_out(msi_req), .msi_addr_out(msi_addr),
    .intx_assert_out(intx), .pme_msg_out(pme), .hot_reset_out(hot),
    .internal_reset_out(irst), .downstream_reset_out_n(dn_n),
    .power_state_out(pstate));
  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    u_host.cfg_read(a, got);
    // Timeout port is left unconnected here, so read the model's flag directly
    if (u_host.timeout_out !== 1'b0)
    begin
      bad_count++;
      end_sim();
    end
    check(got, e);
  endtask
  task automatic irq();
    @(negedge clk_sys_in);
    irq_event_in = 1'b1;
    @(negedge clk_sys_in);
    irq_event_in = 1'b0;
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    rst_in = 1'b0;
  endtask
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      u_host.cfg_write(rows[i].a, rows[i].b, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    u_host.cfg_write(8'h44, 4'h1, 32'h0);
    check({dn_n, irst, hot, pstate}, 5'h14);
    check(pme, 1'b0);
    u_host.cfg_write(8'h44, 4'h2, 32'h100);
    @(negedge clk_sys_in);
    check(pme, 1'b1);
    dflt_load_in = '{load: 1'b1, no_rst: 1'b0, pwr_data: 8'hA5};
    @(negedge clk_sys_in);
    dflt_load_in.load = 1'b0;
    rd(8'h44, 32'hA5000100);
    u_host.cfg_write(8'h44, 4'h1, 32'h3);
    u_host.cfg_write(8'h44, 4'h1, 32'h0);
    check({dn_n, irst, hot}, 3'h7);
    irq();
    check({msi_req, intx}, 2'h1);
    check(msi_addr, 32'h0);
    u_host.cfg_write(8'h4C, 4'h4, 32'h10000);
    irq();
    check({msi_req, intx}, 2'h2);
    check(msi_addr, 32'hFFFFFF00);
    do_reset();
    check(pstate, PS_D0);
    rd(8'h44, 32'h00000008);
    rd(8'h50, 32'h00000000);
    u_host.cfg_write(8'h44, 4'h1, 32'h0);
    check(hot, 1'b0);
    end_sim();
  end
endmodule
